/* File: rtl/llc_consts.svh */
// timing counts and divisor presets for the line-locked clock core
`ifndef LLC_CONSTS_SVH
`define LLC_CONSTS_SVH
`define LLC_CLK_PERIOD_NS 40
`define LLC_SYNC_DELAY_NS 110
`define LLC_SYNC_DELAY_CYC ((`LLC_SYNC_DELAY_NS + `LLC_CLK_PERIOD_NS - 1) / `LLC_CLK_PERIOD_NS)
`define LLC_LOCK_ERR_NS 50
`define LLC_LOCK_ERR_CYC (((`LLC_LOCK_ERR_NS / `LLC_CLK_PERIOD_NS) < 1) ? 1 : (`LLC_LOCK_ERR_NS / `LLC_CLK_PERIOD_NS))
`define LLC_FAST_ERR_CYC 8
`define LLC_DIV_0 12'h6a6
`define LLC_DIV_1 12'h6c0
`define LLC_DIV_2 12'h760
`define LLC_DIV_3 12'h8de
`define LLC_DIV_4 12'h554
`define LLC_DIV_5 12'h6b4
`define LLC_DIV_6 12'h618
`define LLC_DIV_7 12'h71c
`endif

/* File: rtl/llc_pkg.sv */
// types shared by the line-locked clock core
package llc_pkg;
	typedef enum logic [1:0] {
		LLC_MODE_NORMAL = 2'h0,
		LLC_MODE_FAST = 2'h1,
		LLC_MODE_HOLD = 2'h2
	} llc_mode_t;
	typedef struct packed {
		logic up;
		logic down;
	} llc_pump_t;
	typedef enum logic [2:0] {
		LLC_PFD_IDLE = 3'b001,
		LLC_PFD_UP = 3'b010,
		LLC_PFD_DOWN = 3'b100
	} llc_pfd_state_t;
endpackage

/* File: rtl/llc_core.sv */
// line-locked clock divider with phase/frequency detector, modes and lock indicator
`timescale 1ns/1ps
`include "llc_consts.svh"
module llc_core #(
	parameter int DIV_W = 12,
	parameter int ERR_W = 16,
	parameter logic [11:0] DIV_TAB_0 = `LLC_DIV_0,
	parameter logic [11:0] DIV_TAB_1 = `LLC_DIV_1,
	parameter logic [11:0] DIV_TAB_2 = `LLC_DIV_2,
	parameter logic [11:0] DIV_TAB_3 = `LLC_DIV_3,
	parameter logic [11:0] DIV_TAB_4 = `LLC_DIV_4,
	parameter logic [11:0] DIV_TAB_5 = `LLC_DIV_5,
	parameter logic [11:0] DIV_TAB_6 = `LLC_DIV_6,
	parameter logic [11:0] DIV_TAB_7 = `LLC_DIV_7
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic line_sync_n_i,
	input wire logic [2:0] divisor_code_i,
	input wire logic [1:0] mode_code_i,
	input wire logic div_source_internal_i,
	input wire logic divided_clock_port_i,
	output logic divided_clock_port_o,
	output logic divided_clock_port_oe_o,
	output logic pixel_clock_o,
	output llc_pkg::llc_pump_t pump_o,
	output logic pump_drive_o,
	output logic lock_indicator_o,
	output logic signed [ERR_W-1:0] phase_error_o
);
	import llc_pkg::*;

	localparam int DLY = `LLC_SYNC_DELAY_CYC;
	localparam int LOCK_CYC = `LLC_LOCK_ERR_CYC;
	localparam int FAST_CYC = `LLC_FAST_ERR_CYC;

	// =========================================================
	// elaboration checks
	// presets need twelve bits, and the signed error one bit more
	if (DIV_W < 12)
	begin : g_bad_div_w
		$error("llc_core: DIV_W below twelve cannot hold the preset divisors");
	end
	if (ERR_W < DIV_W + 1)
	begin : g_bad_err_w
		$error("llc_core: ERR_W must exceed DIV_W by at least one");
	end
	// the delay line shifts through at least two stages
	if (DLY < 2)
	begin : g_bad_dly
		$error("llc_core: sync delay shorter than two cycles");
	end
	if (FAST_CYC < 1)
	begin : g_bad_fast
		$error("llc_core: fast-lock threshold below one cycle");
	end
	if (LOCK_CYC < 1)
	begin : g_bad_lock
		$error("llc_core: lock window below one cycle");
	end
	// odd totals would lose a cycle when the count is halved
	if (DIV_TAB_0[0] || DIV_TAB_1[0] || DIV_TAB_2[0] || DIV_TAB_3[0]
		|| DIV_TAB_4[0] || DIV_TAB_5[0] || DIV_TAB_6[0] || DIV_TAB_7[0])
	begin : g_bad_tab
		$error("llc_core: preset divisors must be even");
	end

	// =========================================================
	// divisor lookup
	function automatic logic [DIV_W-1:0] div_lookup(input logic [2:0] code);
		logic [11:0] v;
		v = DIV_TAB_0;
		unique case (code)
			3'h0: v = DIV_TAB_0;
			3'h1: v = DIV_TAB_1;
			3'h2: v = DIV_TAB_2;
			3'h3: v = DIV_TAB_3;
			3'h4: v = DIV_TAB_4;
			3'h5: v = DIV_TAB_5;
			3'h6: v = DIV_TAB_6;
			3'h7: v = DIV_TAB_7;
		endcase
		return DIV_W'(v);
	endfunction

	// =========================================================
	// mode decode
	// code 3 has no level of its own and falls into hold
	llc_mode_t mode;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			mode <= LLC_MODE_NORMAL;
		else if (clk_en_i)
		begin
			unique case (mode_code_i)
				2'h0: mode <= LLC_MODE_NORMAL;
				2'h1: mode <= LLC_MODE_FAST;
				default: mode <= LLC_MODE_HOLD;
			endcase
		end
	end

	// =========================================================
	// sync edge delay
	// reference is one clock wide, taken from the sampled falling edge
	logic sync_q;
	logic [DLY-1:0] sync_dly;
	logic sync_ref;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sync_q <= 1'b1;
			sync_dly <= '0;
		end
		else if (clk_en_i)
		begin
			sync_q <= line_sync_n_i;
			sync_dly <= {sync_dly[DLY-2+1-1:0], sync_q & ~line_sync_n_i};
		end
	end
	assign sync_ref = sync_dly[DLY-1];

	// =========================================================
	// pixel clock, halving and divide-by-n
	// total divisor includes halving, so the counter runs to half of it
	logic half_clk;
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] div_half;
	logic int_div_clk;
	logic fast_reset;
	// pixel clock out is a register image; the real clock leaves the pad directly
	assign div_half = div_lookup(divisor_code_i) >> 1;
	assign pixel_clock_o = half_clk;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			half_clk <= 1'b0;
		else if (clk_en_i)
			half_clk <= ~half_clk;
	end
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			div_cnt <= '0;
			int_div_clk <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (fast_reset)
			begin
				div_cnt <= '0;
				int_div_clk <= 1'b1;
			end
			else if (half_clk)
			begin
				if (div_cnt >= div_half - DIV_W'(1))
				begin
					div_cnt <= '0;
					int_div_clk <= 1'b1;
				end
				else
				begin
					div_cnt <= div_cnt + DIV_W'(1);
					if (div_cnt == (div_half >> 1))
						int_div_clk <= 1'b0;
				end
			end
		end
	end

	// =========================================================
	// divided clock source and rising edge
	logic div_src;
	logic div_q;
	logic div_rise;
	// external divider is taken as synchronous; no extra stages are spent on it
	assign divided_clock_port_oe_o = div_source_internal_i;
	assign divided_clock_port_o = int_div_clk & div_source_internal_i;
	assign div_src = div_source_internal_i ? int_div_clk : divided_clock_port_i;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			div_q <= 1'b0;
		else if (clk_en_i)
			div_q <= div_src;
	end
	assign div_rise = div_src & ~div_q;

	// =========================================================
	// phase/frequency detector
	// classic tri-state detector: first edge arms, second edge clears
	llc_pfd_state_t pfd;
	logic [ERR_W-1:0] err_cnt;
	logic hold;
	assign hold = (mode == LLC_MODE_HOLD);
	assign fast_reset = (mode == LLC_MODE_FAST) && (pfd == LLC_PFD_DOWN) && sync_ref
		&& (err_cnt >= ERR_W'(FAST_CYC)) && div_source_internal_i;

	// a window closes on the edge that the other signal was waiting for
	logic up_close;
	logic down_close;
	logic next_up;
	logic next_down;
	assign up_close = !hold && (pfd == LLC_PFD_UP) && div_rise;
	assign down_close = !hold && (pfd == LLC_PFD_DOWN) && (sync_ref || fast_reset);
	// requests follow the detector's next state, so a one-cycle error still drives the pump
	always_comb
	begin
		next_up = 1'b0;
		next_down = 1'b0;
		if (!hold)
		begin
			unique case (pfd)
				LLC_PFD_IDLE:
				begin
					next_up = sync_ref && !div_rise;
					next_down = div_rise && !sync_ref;
				end
				LLC_PFD_UP:
					next_up = !div_rise;
				LLC_PFD_DOWN:
					next_down = !sync_ref && !fast_reset;
			endcase
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pfd <= LLC_PFD_IDLE;
			err_cnt <= '0;
		end
		else if (clk_en_i)
		begin
			if (hold)
			begin
				pfd <= LLC_PFD_IDLE;
				err_cnt <= '0;
			end
			else
			begin
				unique case (pfd)
					LLC_PFD_IDLE:
					begin
						err_cnt <= '0;
						if (sync_ref && !div_rise)
							pfd <= LLC_PFD_UP;
						else if (div_rise && !sync_ref)
							pfd <= LLC_PFD_DOWN;
					end
					LLC_PFD_UP:
					begin
						err_cnt <= err_cnt + ERR_W'(1);
						if (div_rise)
							pfd <= LLC_PFD_IDLE;
					end
					LLC_PFD_DOWN:
					begin
						err_cnt <= err_cnt + ERR_W'(1);
						if (sync_ref || fast_reset)
							pfd <= LLC_PFD_IDLE;
					end
				endcase
			end
		end
	end

	// pump requests: up while divided clock lags, down while it leads
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pump_o <= '0;
			pump_drive_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			pump_o.up <= next_up;
			pump_o.down <= next_down;
			// drive and requests share one source so they can never disagree
			pump_drive_o <= next_up || next_down;
		end
	end

	// =========================================================
	// signed error of last comparison and lock indicator
	// pulses on each comparison whose error reaches 50 ns; stays low when inside it
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			phase_error_o <= '0;
			lock_indicator_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			lock_indicator_o <= 1'b0;
			if (up_close)
			begin
				phase_error_o <= $signed(err_cnt + ERR_W'(1));
				lock_indicator_o <= (err_cnt + ERR_W'(1)) >= ERR_W'(LOCK_CYC + 1);
			end
			else if (down_close)
			begin
				phase_error_o <= -$signed(err_cnt + ERR_W'(1));
				lock_indicator_o <= (err_cnt + ERR_W'(1)) >= ERR_W'(LOCK_CYC + 1);
			end
			else if (!hold && pfd == LLC_PFD_IDLE && sync_ref && div_rise)
				phase_error_o <= '0;
		end
	end
endmodule

/* File: testbench/llc_monitor.sv */
// concurrent checks on the line-locked clock core ports
`timescale 1ns/1ps
module llc_monitor #(
	parameter int ERR_W = 16
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic line_sync_n_i,
	input wire logic [1:0] mode_code_i,
	input wire logic div_source_internal_i,
	input wire logic divided_clock_port_i,
	input wire logic divided_clock_port_oe_o,
	input wire llc_pkg::llc_pump_t pump_o,
	input wire logic pump_drive_o,
	input wire logic lock_indicator_o,
	input wire logic signed [ERR_W-1:0] phase_error_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// ==========
	// properties
	property p_oe; divided_clock_port_oe_o == div_source_internal_i; endproperty
	a_oe: assert property (p_oe) else $error("oe mismatch");
	property p_hold; mode_code_i[1] [*3] |-> !pump_drive_o && !lock_indicator_o; endproperty
	a_hold: assert property (p_hold) else $error("drive in hold");
	property p_excl; !(pump_o.up && pump_o.down); endproperty
	a_excl: assert property (p_excl) else $error("up and down");
	property p_drv; pump_drive_o == (pump_o.up || pump_o.down); endproperty
	a_drv: assert property (p_drv) else $error("drive flag");
	property p_pulse; lock_indicator_o |=> !lock_indicator_o; endproperty
	a_pulse: assert property (p_pulse) else $error("lock pulse long");
	property p_lockerr; lock_indicator_o |-> phase_error_o > 1 || phase_error_o < -1; endproperty
	a_lockerr: assert property (p_lockerr) else $error("lock pulse small error");
	// sync leads a quiet divided clock: up request four cycles after the edge
	property p_ref; ($fell(line_sync_n_i) && mode_code_i == 2'h0 && !div_source_internal_i
		&& !divided_clock_port_i && !pump_drive_o) ##1 !divided_clock_port_i [*4] |-> pump_o.up; endproperty
	a_ref: assert property (p_ref) else $error("no up request");
	property p_sign; $fell(pump_drive_o) |-> phase_error_o != 0 && (phase_error_o > 0) == $past(pump_o.up); endproperty
	a_sign: assert property (p_sign) else $error("error sign");
endmodule
bind llc_core llc_monitor #(.ERR_W(ERR_W)) i_llc_monitor (.clk_i, .reset_i, .line_sync_n_i, .mode_code_i,
	.div_source_internal_i, .divided_clock_port_i, .divided_clock_port_oe_o, .pump_o, .pump_drive_o,
	.lock_indicator_o, .phase_error_o);

/* File: testbench/llc_partner.sv */
// line sync source and external divider facing the core
`timescale 1ns/1ps
module llc_partner (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic signed [7:0] lag_i,
	output logic line_sync_n_o,
	output logic div_clk_o
);
	int t = 99;
	initial
	begin
		line_sync_n_o = 1'b1;
		div_clk_o = 1'b0;
	end
	// ==========
	// one line: sync falls at 8, divider rises lag cycles after the reference
	always @(posedge clk_i)
	begin
		if (go_i)
			t = 0;
		else if (t < 99)
			t++;
		line_sync_n_o <= t < 8 || t > 11;
		div_clk_o <= t >= 11 + lag_i && t < 15 + lag_i;
	end
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the line-locked clock core
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_errors++; $display("[ERR] %s exp %0d got %0d", nm, ex, gt); end end
module testbench;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic go = 1'b0;
	logic src = 1'b0;
	logic [2:0] code = 3'h0;
	logic [1:0] mode = 2'h0;
	logic signed [7:0] lag = 8'sh0;
	logic sync_n, divided_clock_port, div_o, drive, lock, up_seen, drv_prev;
	llc_pkg::llc_pump_t pump;
	logic signed [15:0] err;
	int n_errors = 0;
	int n_compared = 0;
	int q[$];
	int e, l, n;
	int lags[9] = '{3, -3, 2, -2, 1, -1, 7, -7, 0};
	logic [11:0] tab[8] = '{12'h6a6, 12'h6c0, 12'h760, 12'h8de, 12'h554, 12'h6b4, 12'h618, 12'h71c};
	initial
		forever #20 clk_i = ~clk_i;
	llc_core i_llc_core (.clk_i, .reset_i, .clk_en_i(1'b1), .line_sync_n_i(sync_n), .divisor_code_i(code),
		.mode_code_i(mode), .div_source_internal_i(src), .divided_clock_port_i(divided_clock_port),
		.divided_clock_port_o(div_o), .divided_clock_port_oe_o(), .pixel_clock_o(), .pump_o(pump),
		.pump_drive_o(drive), .lock_indicator_o(lock), .phase_error_o(err));
	llc_partner i_llc_partner (.clk_i, .go_i(go), .lag_i(lag), .line_sync_n_o(sync_n), .div_clk_o(divided_clock_port));
	// ==========
	// result watcher: an empty queue flags any unexpected pump window
	always @(negedge clk_i)
	begin
		if (drv_prev === 1'b1 && drive === 1'b0)
		begin
			e = (q.size() > 0) ? q.pop_front() : 99;
			`CHK("phase_error", e, err)
			`CHK("lock", (e > 1 || e < -1), lock)
			`CHK("up", e > 0, up_seen)
		end
		if (drive)
			up_seen = pump.up;
		drv_prev = drive;
	end
	task automatic send(input int v);
		lag = 8'(v);
		go = 1'b1;
		@(negedge clk_i);
		go = 1'b0;
		repeat (30) @(negedge clk_i);
	endtask
	task automatic rise(output int c);
		logic p;
		c = 0;
		p = div_o;
		while (c < 5000 && !(div_o && !p))
		begin
			p = div_o;
			@(negedge clk_i);
			c++;
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk_i);
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		void'($urandom(8889));
		repeat (10) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (5) @(negedge clk_i);
		`CHK("ext port", 1'b0, div_o)
		// mode stays normal here because mode code 0 is held
		for (int i = 0; i < 13; i++)
		begin
			l = (i < 9) ? lags[i] : $urandom_range(7, 1) * ($urandom_range(1, 0) ? 1 : -1);
			if (l != 0)
				q.push_back(l);
			send(l);
		end
		$display("test detector done");
		// hold codes 2 and 3 must ignore a lagging edge
		for (int m = 2; m < 4; m++)
		begin
			mode = 2'(m);
			repeat (3) @(negedge clk_i);
			send(4);
		end
		$display("test hold done");
		src = 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			code = 3'(k);
			rise(n);
			rise(n);
			rise(n);
			`CHK("period", 32'(tab[k]), n)
		end
		$display("test divider done");
		tally_and_finish();
	end
endmodule
